// *** src/rsa_aux.sv ***
`timescale 1ns/10ps
module rsa_aux (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register access
  input wire rsa_pkg::rsa_reg_wr_t reg_wr,
  input wire logic [9:0] reg_rd_addr,
  output logic [7:0] reg_rd_data,
  // Sample timing
  input wire logic rx_sample_en,
  // External amp control
  input wire rsa_pkg::rsa_front_word_t rx1_front_word,
  input wire rsa_pkg::rsa_front_word_t rx2_front_word,
  input wire logic rx1_ext_amp_ctrl_en,
  input wire logic rx2_ext_amp_ctrl_en,
  output logic rx1_general_output,
  output logic rx2_general_output,
  // RF offset calibration
  input wire logic cal_step,
  input wire logic [6:0] cal_index,
  input wire rsa_pkg::rsa_dig_word_t cal_dig_word,
  input wire logic cal_word_valid,
  input wire logic [7:0] cal_word,
  output logic cal_offset_run,
  input wire logic [6:0] rx_gain_index,
  output logic [7:0] rf_correction_word,
  // Peak detector gating
  input wire logic gain_change,
  input wire logic [7:0] peak_wait_time,
  output logic peak_detect_enable,
  // RSSI events and settings
  input wire logic fast_attack_lock,
  input wire logic gain_control_enable_pin,
  input wire logic rx_enter,
  input wire logic [7:0] settle_delay,
  input wire logic [7:0] rssi_wait,
  input wire logic [7:0] sample_power,
  input wire logic [7:0] rx_path_gain,
  input wire logic [5:0] external_amp_high_gain,
  input wire logic [5:0] external_amp_low_gain,
  // RSSI results
  output logic [8:0] rssi_symbol,
  output logic [8:0] rssi_preamble,
  output logic rssi_update
);
  rsa_pkg::rsa_state_t state;
  logic [7:0] dur_lo, dur_hi;
  logic [2:0] rssi_restart_event_select;
  logic default_measurement_mode_flag;
  logic [6:0] max_index;
  logic sw_restart;
  logic en_s1, en_s2, en_s3, en_rise;
  logic restart, gain_restart;
  logic [7:0] corr_tbl [0:127];
  logic [7:0] last_corr;
  logic [6:0] cal_idx_q;
  logic [7:0] pk_cnt;
  logic [2:0] div_cnt;
  logic [7:0] set_cnt, wait_cnt;
  logic [14:0] samp_cnt;
  logic [23:0] acc;
  logic [17:0] wacc;
  logic [1:0] sub;
  logic first;
  logic [7:0] mult [0:3];
  logic [17:0] total;
  logic [3:0] cur_dur;
  logic [7:0] cur_avg;
  logic [17:0] next_wacc;
  logic [9:0] pwr;
  logic [10:0] comp;

  // Two raised to a four-bit duration field
  function automatic logic [17:0] pow2(input logic [3:0] d);
    pow2 = 18'h00001 << d;
  endfunction : pow2

  // Duration field of one sub-measurement
  function automatic logic [3:0] dur_of(input logic [15:0] f, input logic [1:0] i);
    dur_of = f[{i, 2'b00} +: 4];
  endfunction : dur_of

  // Divide by 255, close approximation
  function automatic logic [9:0] div255(input logic [17:0] x);
    logic [18:0] t;
    t = {1'b0, x} + {9'h000, x[17:8]} + 19'h00001;
    div255 = t[17:8];
  endfunction : div255

  // Multiplier for one sub-measurement
  function automatic logic [7:0] weight(input logic [3:0] d, input logic [17:0] tot);
    logic [25:0] num;
    num = {8'h00, pow2(d)} * 26'd255;
    weight = 8'((num / {8'h00, tot}));
  endfunction : weight

  // Register writes and the self-clearing restart strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dur_lo <= rsa_pkg::DUR_RST;
      dur_hi <= rsa_pkg::DUR_RST;
      rssi_restart_event_select <= rsa_pkg::RSA_FAST_LOCK;
      default_measurement_mode_flag <= 1'b0;
      max_index <= rsa_pkg::MAX_INDEX_RST;
      sw_restart <= 1'b0;
    end else begin
      sw_restart <= 1'b0;
      if (reg_wr.en) begin
        unique case (reg_wr.addr)
          rsa_pkg::REG_DUR_LO: dur_lo <= reg_wr.data;
          rsa_pkg::REG_DUR_HI: dur_hi <= reg_wr.data;
          rsa_pkg::REG_RESTART: begin
            rssi_restart_event_select <= reg_wr.data[rsa_pkg::SEL_LSB +: 3];
            default_measurement_mode_flag <= reg_wr.data[rsa_pkg::DEF_MODE_BIT];
            sw_restart <= reg_wr.data[rsa_pkg::SW_RESTART_BIT];
          end
          rsa_pkg::REG_MAX_INDEX: max_index <= reg_wr.data[6:0];
          default: ;
        endcase
      end
    end
  end

  // Register read-back, restart bit reads zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rd_data <= 8'h00;
    end else begin
      unique case (reg_rd_addr)
        rsa_pkg::REG_DUR_LO: reg_rd_data <= dur_lo;
        rsa_pkg::REG_DUR_HI: reg_rd_data <= dur_hi;
        rsa_pkg::REG_RESTART: reg_rd_data <= {4'h0, default_measurement_mode_flag,
                                              rssi_restart_event_select};
        rsa_pkg::REG_MAX_INDEX: reg_rd_data <= {1'b0, max_index};
        rsa_pkg::REG_STATUS: reg_rd_data <= {2'b00, cal_offset_run, peak_detect_enable,
                                             state};
        default: reg_rd_data <= 8'h00;
      endcase
    end
  end

  // Enable pin synchroniser and rising edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
      en_s3 <= 1'b0;
    end else begin
      en_s1 <= gain_control_enable_pin;
      en_s2 <= en_s1;
      en_s3 <= en_s2;
    end
  end
  assign en_rise = en_s2 & ~en_s3;

  // Restart event selection
  always_comb begin
    restart = 1'b0;
    gain_restart = 1'b0;
    unique case (rssi_restart_event_select)
      rsa_pkg::RSA_FAST_LOCK: restart = fast_attack_lock;
      rsa_pkg::RSA_EN_RISE: restart = en_rise;
      rsa_pkg::RSA_RX_ENTER: restart = rx_enter;
      rsa_pkg::RSA_GAIN_CHG: begin
        restart = gain_change;
        gain_restart = gain_change;
      end
      rsa_pkg::RSA_SW_WRITE: restart = sw_restart;
      rsa_pkg::RSA_GAIN_OR_EN: begin
        restart = gain_change | en_rise;
        gain_restart = gain_change;
      end
      default: restart = 1'b0;
    endcase
  end

  // Flagged indices calibrate, others inherit the last word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cal_offset_run <= 1'b0;
      last_corr <= 8'h00;
      cal_idx_q <= 7'h00;
      rf_correction_word <= 8'h00;
      for (int i = 0; i < 128; i++) corr_tbl[i] <= 8'h00;
    end else begin
      rf_correction_word <= corr_tbl[rx_gain_index];
      if (cal_offset_run) begin
        if (cal_word_valid) begin
          cal_offset_run <= 1'b0;
          last_corr <= cal_word;
          corr_tbl[cal_idx_q] <= cal_word;
        end
      end else if (cal_step && cal_index <= max_index) begin
        if (cal_dig_word.rf_offset_calibrate_flag) begin
          cal_offset_run <= 1'b1;
          cal_idx_q <= cal_index;
        end else begin
          corr_tbl[cal_index] <= last_corr;
        end
      end
    end
  end

  // External amp bits onto the general outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx1_general_output <= 1'b0;
      rx2_general_output <= 1'b0;
    end else begin
      rx1_general_output <= rx1_ext_amp_ctrl_en & rx1_front_word.ext_amp_bit;
      rx2_general_output <= rx2_ext_amp_ctrl_en & rx2_front_word.ext_amp_bit;
    end
  end

  // Peak detectors held off for the wait time after a gain change
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pk_cnt <= 8'h00;
      peak_detect_enable <= 1'b1;
    end else if (gain_change) begin
      pk_cnt <= peak_wait_time;
      peak_detect_enable <= 1'b0;
    end else if (!peak_detect_enable && rx_sample_en) begin
      if (pk_cnt == 8'h00) peak_detect_enable <= 1'b1;
      else pk_cnt <= pk_cnt - 8'h01;
    end
  end

  // Sub-measurement arithmetic
  always_comb begin
    total = default_measurement_mode_flag ? pow2(dur_lo[3:0])
      : pow2(dur_lo[3:0]) + pow2(dur_lo[7:4]) + pow2(dur_hi[3:0])
        + pow2(dur_hi[7:4]);
    cur_dur = dur_of({dur_hi, dur_lo}, sub);
    cur_avg = 8'((acc + {16'h0000, sample_power}) >> cur_dur);
    next_wacc = wacc + 18'(cur_avg * mult[sub]);
    pwr = div255(next_wacc);
    comp = {1'b0, pwr} - {3'h0, rx_path_gain}
      - {5'h00, (rx1_front_word.ext_amp_bit ? external_amp_high_gain
                                            : external_amp_low_gain)};
  end

  // Settle, measure and wait sequence
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= rsa_pkg::RSA_IDLE;
      div_cnt <= 3'h0;
      set_cnt <= 8'h00;
      wait_cnt <= 8'h00;
      samp_cnt <= 15'h0000;
      acc <= 24'h000000;
      wacc <= 18'h00000;
      sub <= 2'h0;
      first <= 1'b0;
      rssi_symbol <= 9'h000;
      rssi_preamble <= 9'h000;
      rssi_update <= 1'b0;
      for (int i = 0; i < 4; i++) mult[i] <= rsa_pkg::MULT_NONE;
    end else begin
      rssi_update <= 1'b0;
      if (restart) begin
        state <= rsa_pkg::RSA_SETTLE;
        div_cnt <= 3'h0;
        set_cnt <= settle_delay;
        acc <= 24'h000000;
        wacc <= 18'h00000;
        samp_cnt <= 15'h0000;
        sub <= 2'h0;
        first <= ~gain_restart;
        for (int i = 0; i < 4; i++) begin
          if (default_measurement_mode_flag)
            mult[i] <= (i == 0) ? rsa_pkg::MULT_FULL : rsa_pkg::MULT_NONE;
          else
            mult[i] <= weight(dur_of({dur_hi, dur_lo}, 2'(i)), total);
        end
      end else if (rx_sample_en) begin
        unique case (state)
          rsa_pkg::RSA_IDLE: ;
          rsa_pkg::RSA_SETTLE: begin
            div_cnt <= div_cnt + 3'h1;
            if (div_cnt == rsa_pkg::SETTLE_DIV_LAST) begin
              if (set_cnt == 8'h00) state <= rsa_pkg::RSA_MEAS;
              else set_cnt <= set_cnt - 8'h01;
            end
          end
          rsa_pkg::RSA_MEAS: begin
            if ({3'h0, samp_cnt} == pow2(cur_dur) - 18'h00001) begin
              acc <= 24'h000000;
              samp_cnt <= 15'h0000;
              if (default_measurement_mode_flag || sub == rsa_pkg::SUB_LAST) begin
                wacc <= 18'h00000;
                sub <= 2'h0;
                wait_cnt <= rssi_wait;
                state <= rsa_pkg::RSA_WAIT;
                rssi_symbol <= comp[10] ? 9'h000 : (comp[9] ? 9'h1ff : comp[8:0]);
                if (first) rssi_preamble <= comp[10] ? 9'h000
                  : (comp[9] ? 9'h1ff : comp[8:0]);
                first <= 1'b0;
                rssi_update <= 1'b1;
              end else begin
                wacc <= next_wacc;
                sub <= sub + 2'h1;
              end
            end else begin
              acc <= acc + {16'h0000, sample_power};
              samp_cnt <= samp_cnt + 15'h0001;
            end
          end
          rsa_pkg::RSA_WAIT: begin
            if (wait_cnt == 8'h00) state <= rsa_pkg::RSA_MEAS;
            else wait_cnt <= wait_cnt - 8'h01;
          end
        endcase
      end
    end
  end
endmodule : rsa_aux

// *** src/rsa_pkg.sv ***
// Functional notes
// - Flagged gain index runs RF offset reduction during calibration.
// - Flagged index correction word reused by higher unflagged indices.
// - Calibration limited to indices up to max index, reset 76h.
// - Rx1 ext-amp bit drives output one, Rx2 drives output two.
// - Bit zero gives low output level, one gives high.
// - Ext-amp bits reach outputs only when per-receiver enables set.
// - After each gain change wait peak wait time before peak detect.
// - External amp gains unsigned 0.5 dB steps, used in compensation.
// - Three-bit select picks restart event; restart clears accumulator.
// - Codes 000,001,010,011,101 map to their documented restart events.
// - Code 100 restarts on software write of restart bit.
// - Default mode duration is two to the first duration field.
// - Non-default duration sums four power-of-two duration fields.
// - Durations counted in receive sample cycles.
// - Non-default multipliers are 255 times duration over total.
// - Default mode loads multiplier zero FFh, others 00h.
// - Settle delay counted at sample rate over eight after restart.
// - After settle, alternate measurement and programmed wait intervals.
// - Gain-change modes reset accumulator on every gain change.
// - Calibration flag held in digital gain word beside digital index.
// - Ext-amp bit held in front-end word with LNA and mixer indices.
// - First result after a restart not caused by gain change to preamble and symbol; later only symbol.
package rsa_pkg;
  // Register offsets
  localparam logic [9:0] REG_DUR_LO = 10'h150;
  localparam logic [9:0] REG_DUR_HI = 10'h151;
  localparam logic [9:0] REG_RESTART = 10'h158;
  localparam logic [9:0] REG_MAX_INDEX = 10'h15e;
  localparam logic [9:0] REG_STATUS = 10'h15f;
  // Field positions and reset values
  localparam int SEL_LSB = 0;
  localparam int DEF_MODE_BIT = 3;
  localparam int SW_RESTART_BIT = 5;
  localparam logic [6:0] MAX_INDEX_RST = 7'h76;
  localparam logic [7:0] DUR_RST = 8'h00;
  localparam logic [2:0] SETTLE_DIV_LAST = 3'h7;
  localparam logic [7:0] MULT_FULL = 8'hff;
  localparam logic [7:0] MULT_NONE = 8'h00;
  localparam logic [1:0] SUB_LAST = 2'h3;
  typedef enum logic [2:0] {
    RSA_FAST_LOCK = 3'h0,
    RSA_EN_RISE = 3'h1,
    RSA_RX_ENTER = 3'h2,
    RSA_GAIN_CHG = 3'h3,
    RSA_SW_WRITE = 3'h4,
    RSA_GAIN_OR_EN = 3'h5
  } rsa_restart_t;
  typedef enum logic [3:0] {
    RSA_IDLE = 4'b0001,
    RSA_SETTLE = 4'b0010,
    RSA_MEAS = 4'b0100,
    RSA_WAIT = 4'b1000
  } rsa_state_t;
  // Front-end gain word: ext-amp bit, LNA and mixer indices
  typedef struct packed {
    logic ext_amp_bit;
    logic [1:0] lna_index;
    logic [3:0] mixer_index;
  } rsa_front_word_t;
  // Digital gain word: calibration flag and digital index
  typedef struct packed {
    logic rf_offset_calibrate_flag;
    logic [4:0] digital_index;
  } rsa_dig_word_t;
  // Decoded serial register write
  typedef struct packed {
    logic en;
    logic [9:0] addr;
    logic [7:0] data;
  } rsa_reg_wr_t;
endpackage : rsa_pkg

// *** tb/rsa_bbp_model.sv ***
`timescale 1ns/10ps
module rsa_host_model (
  // Clock
  input wire logic clk,
  // Register side
  output rsa_pkg::rsa_reg_wr_t reg_wr,
  output logic [9:0] reg_rd_addr,
  input wire logic [7:0] reg_rd_data,
  // External amp gains
  output logic [5:0] external_amp_high_gain,
  output logic [5:0] external_amp_low_gain
);
  // Idle bus at time zero
  initial begin
    reg_wr = '0;
    reg_rd_addr = 10'h3ff;
    external_amp_high_gain = 6'h00;
    external_amp_low_gain = 6'h00;
  end
  // One write, strobe for one cycle, then lines inverted
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = '{en: 1'b1, addr: a, data: d};
    @(negedge clk);
    reg_wr = '{en: 1'b0, addr: ~a, data: ~d};
  endtask : wr
  // Read, data one edge after address
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd_addr = a;
    @(negedge clk);
    d = reg_rd_data;
  endtask : rd
  // Limit follows the loaded table size
  task automatic set_table_size(input int n);
    wr(rsa_pkg::REG_MAX_INDEX, 8'(n - 1));
  endtask : set_table_size
  // Negative low gain folded into high gain, half-dB units
  task automatic set_gains(input int hi, input int lo);
    if (lo < 0) begin
      hi = hi - lo;
      lo = 0;
    end
    external_amp_high_gain = 6'(hi);
    external_amp_low_gain = 6'(lo);
  endtask : set_gains
endmodule : rsa_host_model

// *** tb/rsa_props.sv ***
`timescale 1ns/10ps
module rsa_props (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Inputs watched
  input wire rsa_pkg::rsa_reg_wr_t reg_wr,
  input wire rsa_pkg::rsa_front_word_t rx1_front_word,
  input wire rsa_pkg::rsa_front_word_t rx2_front_word,
  input wire logic rx1_ext_amp_ctrl_en,
  input wire logic rx2_ext_amp_ctrl_en,
  input wire logic cal_step,
  input wire logic [6:0] cal_index,
  input wire rsa_pkg::rsa_dig_word_t cal_dig_word,
  input wire logic cal_word_valid,
  input wire logic gain_change,
  // Outputs watched
  input wire logic rx1_general_output,
  input wire logic rx2_general_output,
  input wire logic cal_offset_run,
  input wire logic peak_detect_enable,
  input wire logic [8:0] rssi_symbol,
  input wire logic rssi_update
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [6:0] max_index;
  // Shadow of the calibration index limit
  always_ff @(posedge clk) begin
    if (sys_rst) max_index <= rsa_pkg::MAX_INDEX_RST;
    else if (reg_wr.en && reg_wr.addr == rsa_pkg::REG_MAX_INDEX) max_index <= reg_wr.data[6:0];
  end
  a_amp_out_one: assert property (
    !$past(sys_rst) |-> rx1_general_output == $past(rx1_ext_amp_ctrl_en && rx1_front_word[6]))
    else $error("rx1 output wrong");
  a_amp_out_two: assert property (
    !$past(sys_rst) |-> rx2_general_output == $past(rx2_ext_amp_ctrl_en && rx2_front_word[6]))
    else $error("rx2 output wrong");
  a_cal_run_start: assert property (
    cal_step && !cal_offset_run && cal_dig_word[5] && cal_index <= max_index |=> cal_offset_run)
    else $error("offset run not started");
  a_cal_over_max: assert property (
    cal_step && !cal_offset_run && cal_index > max_index |=> !cal_offset_run)
    else $error("index above limit ran");
  a_cal_run_hold: assert property (
    cal_offset_run && !cal_word_valid |=> cal_offset_run) else $error("offset run dropped");
  a_cal_run_end: assert property (
    cal_offset_run && cal_word_valid |=> !cal_offset_run) else $error("offset run stuck");
  a_peak_wait_gate: assert property (
    gain_change |=> !peak_detect_enable ##[1:1000] peak_detect_enable)
    else $error("peak gate wrong");
  a_update_one_pulse: assert property (
    rssi_update |=> !rssi_update) else $error("update too long");
  a_symbol_on_update: assert property (
    $changed(rssi_symbol) |-> rssi_update || $past(rssi_update))
    else $error("symbol moved alone");
endmodule : rsa_props

bind rsa_aux rsa_props rsa_props_inst (.clk, .sys_rst, .reg_wr, .rx1_front_word,
  .rx2_front_word, .rx1_ext_amp_ctrl_en, .rx2_ext_amp_ctrl_en, .cal_step, .cal_index,
  .cal_dig_word, .cal_word_valid, .gain_change, .rx1_general_output, .rx2_general_output,
  .cal_offset_run, .peak_detect_enable, .rssi_symbol, .rssi_update);

// *** tb/tb.sv ***
`timescale 1ns/10ps
module tb;
  logic clk = 0, sys_rst = 1, rx_sample_en = 1, rx1_ext_amp_ctrl_en = 0, rx2_ext_amp_ctrl_en = 0;
  logic rx1_general_output, rx2_general_output, cal_step = 0, cal_word_valid = 0, cal_offset_run;
  logic gain_change = 0, peak_detect_enable, fast_attack_lock = 0, rx_enter = 0, rssi_update;
  logic gain_control_enable_pin = 0, slow = 0;
  logic [9:0] reg_rd_addr;
  logic [7:0] reg_rd_data, cal_word = 0, rf_correction_word, peak_wait_time = 3;
  logic [7:0] settle_delay = 1, rssi_wait = 3, sample_power = 200, rx_path_gain = 20;
  logic [6:0] cal_index = 0, rx_gain_index = 0;
  logic [5:0] external_amp_high_gain, external_amp_low_gain;
  logic [8:0] rssi_symbol, rssi_preamble;
  rsa_pkg::rsa_reg_wr_t reg_wr;
  rsa_pkg::rsa_front_word_t rx1_front_word = 7'h15, rx2_front_word = 7'h2a;
  rsa_pkg::rsa_dig_word_t cal_dig_word = 0;
  int errors = 0, num_checks = 0;
  rsa_aux rsa_aux_inst (.clk, .sys_rst, .reg_wr, .reg_rd_addr, .reg_rd_data, .rx_sample_en,
    .rx1_front_word, .rx2_front_word, .rx1_ext_amp_ctrl_en, .rx2_ext_amp_ctrl_en,
    .rx1_general_output, .rx2_general_output, .cal_step, .cal_index, .cal_dig_word,
    .cal_word_valid, .cal_word, .cal_offset_run, .rx_gain_index, .rf_correction_word,
    .gain_change, .peak_wait_time, .peak_detect_enable, .fast_attack_lock,
    .gain_control_enable_pin, .rx_enter, .settle_delay, .rssi_wait, .sample_power, .rx_path_gain,
    .external_amp_high_gain, .external_amp_low_gain, .rssi_symbol, .rssi_preamble, .rssi_update);
  rsa_host_model rsa_host_model_inst (.clk, .reg_wr, .reg_rd_addr, .reg_rd_data,
    .external_amp_high_gain, .external_amp_low_gain);
  // Clock and watchdog
  always #5 clk = ~clk;
  // Sample strobe, every other cycle while slow is set
  always @(negedge clk) rx_sample_en = slow ? ~rx_sample_en : 1'b1;
  initial begin
    #200000;
    errors++;
    end_of_test;
  end
  task automatic end_of_test;
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic do_reset;
    sys_rst = 1;
    repeat (3) @(negedge clk);
    sys_rst = 0;
  endtask : do_reset
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1;
    @(negedge clk);
    s = 0;
  endtask : pulse
  task automatic wait_upd(output int n);
    n = 0;
    while (rssi_update !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
  endtask : wait_upd
  // Weighted power with the hand-over divide, minus path and amp gain
  function automatic logic [8:0] expv(input int p, input int m, input int g);
    int x;
    x = p * m;
    x = (x + (x >> 8) + 1) >> 8;
    return 9'(x - 20 - g);
  endfunction : expv
  task automatic t_regs;
    logic [7:0] d;
    rsa_host_model_inst.rd(rsa_pkg::REG_STATUS, d);
    chk("status", 9'(d), 9'h011);
    rsa_host_model_inst.rd(rsa_pkg::REG_MAX_INDEX, d);
    chk("max index", 9'(d), 9'h076);
    rsa_host_model_inst.rd(10'h100, d);
    chk("unmapped", 9'(d), 9'h000);
    rsa_host_model_inst.wr(rsa_pkg::REG_DUR_LO, 8'ha5);
    rsa_host_model_inst.rd(rsa_pkg::REG_DUR_LO, d);
    chk("durations", 9'(d), 9'h0a5);
    rsa_host_model_inst.wr(rsa_pkg::REG_RESTART, 8'h2e);
    rsa_host_model_inst.rd(rsa_pkg::REG_RESTART, d);
    chk("restart reg", 9'(d), 9'h00e);
  endtask : t_regs
  task automatic t_amp_out;
    for (int i = 0; i < 16; i++) begin
      rx1_ext_amp_ctrl_en = i[0];
      rx1_front_word.ext_amp_bit = i[1];
      rx2_ext_amp_ctrl_en = i[2];
      rx2_front_word.ext_amp_bit = i[3];
      repeat (2) @(negedge clk);
      chk("amp out one", 9'(rx1_general_output), 9'(i[0] & i[1]));
      chk("amp out two", 9'(rx2_general_output), 9'(i[2] & i[3]));
    end
  endtask : t_amp_out
  task automatic cal(input logic [6:0] idx, input logic f, input logic exp_run);
    @(negedge clk);
    cal_step = 1;
    cal_index = idx;
    cal_dig_word = '{rf_offset_calibrate_flag: f, digital_index: 5'h03};
    @(negedge clk);
    cal_step = 0;
    chk("offset run", 9'(cal_offset_run), 9'(exp_run));
  endtask : cal
  task automatic t_cal;
    rsa_host_model_inst.set_table_size(41);
    cal(7'h00, 1, 1);
    cal_word = 8'h3c;
    pulse(cal_word_valid);
    chk("run end", 9'(cal_offset_run), 9'h000);
    cal(7'h01, 0, 0);
    cal(7'h02, 0, 0);
    rx_gain_index = 7'h02;
    repeat (2) @(negedge clk);
    chk("shared word", 9'(rf_correction_word), 9'h03c);
    cal(7'h29, 1, 0);
  endtask : t_cal
  task automatic t_peak;
    int n;
    for (int s = 0; s < 2; s++) begin
      slow = s[0];
      pulse(gain_change);
      chk("peak low", 9'(peak_detect_enable), 9'h000);
      n = 0;
      while (peak_detect_enable !== 1'b1 && n < 50) begin
        @(negedge clk);
        n++;
      end
      chk("peak wait", 9'(n >= 4 + 3 * s && n <= 4 + 4 * s), 9'h001);
    end
    slow = 0;
  endtask : t_peak
  task automatic t_modes;
    int n;
    for (int c = 0; c < 7; c++) begin
      do_reset;
      rsa_host_model_inst.wr(rsa_pkg::REG_RESTART, 8'h08 | 8'(c));
      case (c)
        0: pulse(fast_attack_lock);
        1: gain_control_enable_pin = 1;
        2: pulse(rx_enter);
        4: rsa_host_model_inst.wr(rsa_pkg::REG_RESTART, 8'h2c);
        default: pulse(gain_change);
      endcase
      wait_upd(n);
      chk("restart", 9'(n < 300), 9'(c < 6));
      chk("preamble gate", 9'(rssi_preamble != 9'h000), 9'(c < 3 || c == 4));
      gain_control_enable_pin = 0;
    end
  endtask : t_modes
  task automatic t_rssi(input logic [7:0] lo, input logic [7:0] m, input logic x,
      input int span, input int mult, input int g);
    int n;
    rx1_front_word.ext_amp_bit = x;
    sample_power = 200;
    rsa_host_model_inst.wr(rsa_pkg::REG_DUR_LO, lo);
    rsa_host_model_inst.wr(rsa_pkg::REG_DUR_HI, 8'h00);
    rsa_host_model_inst.wr(rsa_pkg::REG_RESTART, m);
    rsa_host_model_inst.wr(rsa_pkg::REG_RESTART, m | 8'h20);
    wait_upd(n);
    chk("settle", 9'(n >= 16 + span && n <= 21 + span), 9'h001);
    chk("symbol", rssi_symbol, expv(200, mult, g));
    chk("preamble", rssi_preamble, expv(200, mult, g));
    sample_power = 100;
    wait_upd(n);
    chk("wait gap", 9'(n >= span + 2 && n <= span + 6), 9'h001);
    chk("symbol next", rssi_symbol, expv(100, mult, g));
    chk("preamble kept", rssi_preamble, expv(200, mult, g));
  endtask : t_rssi
  // Main sequence
  initial begin
    do_reset;
    t_regs;
    t_amp_out;
    t_cal;
    t_peak;
    t_modes;
    rsa_host_model_inst.set_gains(30, -10);
    t_rssi(8'h01, 8'h0c, 0, 2, 255, 0);
    t_rssi(8'h21, 8'h04, 1, 8, 252, 40);
    end_of_test;
  end
endmodule : tb
